/* logic/gpt_timer.sv */
// module: 32-bit general timer (one-shot, periodic, real-time clock)
module gpt_timer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // software control
   input wire gpt_pkg::gpt_ctrl_t ctrl_in,
   input wire logic ctrl_write,
   input wire logic load_write,
   input wire logic [31:0] load_data,
   input wire logic match_write,
   input wire logic [31:0] match_data,
   input wire logic prescale_write,
   input wire logic [15:0] prescale_data,
   input wire logic timeout_clear,
   input wire logic clock_match_clear,
   // system
   input wire logic debug_halt,
   input wire logic capture_pin_0,
   // status and data out
   output gpt_pkg::gpt_ctrl_t ctrl_out,
   output gpt_pkg::gpt_status_t status,
   output logic [31:0] half_a_value_reg,
   output logic [15:0] half_a_load_reg,
   output logic [15:0] half_b_load_reg,
   output logic [7:0] half_a_prescale_reg,
   output logic [7:0] half_b_prescale_reg,
   output logic [31:0] half_a_match_reg,
   output logic controller_irq,
   output logic trigger
);
   import gpt_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   gpt_ctrl_t ctrl_reg;
   gpt_status_t status_reg;
   gpt_state_t state_reg;
   logic [15:0] half_a_count_reg;
   logic [15:0] half_b_count_reg;
   logic rtc_seen_reg;
   logic rtc_tick;
   logic reload_pend_reg;
   logic [31:0] count;
   logic [31:0] load_val;
   logic stalled;
   logic rtc_mode;
   logic zero_hit;
   logic rtc_hit;

   assign count = {half_b_count_reg, half_a_count_reg};
   assign load_val = {half_b_load_reg, half_a_load_reg};
   assign rtc_mode = (ctrl_reg.config_sel == GPT_CFG_RTC);
   assign stalled = debug_halt && (ctrl_reg.half_a_debug_stall || ctrl_reg.half_b_debug_stall)
                    && !ctrl_reg.clock_mode_enable;
   assign zero_hit = (state_reg == GPT_ST_COUNT) && ctrl_reg.half_a_enable && !stalled && !reload_pend_reg
                     && (count == GPT_ZERO);
   assign rtc_hit = (state_reg == GPT_ST_RTC) && rtc_tick && (count == half_a_match_reg);

   // divider from the even capture pin
   gpt_rtc_div u_div (
      .core_clk(core_clk),
      .rst(rst),
      .run(state_reg == GPT_ST_RTC),
      .clk_in(capture_pin_0),
      .tick(rtc_tick)
   );

   // ==========================================================
   // control register
   // ==========================================================
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= '0;
      end else if (ctrl_write) begin
         ctrl_reg <= ctrl_in;
      end else if (state_reg == GPT_ST_IDLE && reload_pend_reg == 1'b0 && zero_hit) begin
         ctrl_reg.half_a_enable <= 1'b0;
      end else if (reload_pend_reg && ctrl_reg.half_a_mode != GPT_MODE_PERIODIC
                   && !rtc_mode) begin
         ctrl_reg.half_a_enable <= 1'b0;
      end
   end

   // ==========================================================
   // load, match, prescale registers
   // ==========================================================
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_a_load_reg <= GPT_HALF_RESET;
         half_b_load_reg <= GPT_HALF_RESET;
      end else if (load_write) begin
         half_a_load_reg <= load_data[15:0];
         half_b_load_reg <= load_data[31:16];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_a_match_reg <= GPT_ZERO;
      end else if (match_write) begin
         half_a_match_reg <= match_data;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_a_prescale_reg <= GPT_PRESCALE_RESET;
         half_b_prescale_reg <= GPT_PRESCALE_RESET;
      end else if (prescale_write) begin
         half_a_prescale_reg <= prescale_data[7:0];
         half_b_prescale_reg <= prescale_data[15:8];
      end
   end

   // ==========================================================
   // mode state machine
   // ==========================================================
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= GPT_ST_IDLE;
      end else begin
         unique case (state_reg)
            GPT_ST_IDLE: begin
               if (ctrl_reg.half_a_enable && ctrl_reg.config_sel == GPT_CFG_32BIT) begin
                  state_reg <= GPT_ST_COUNT;
               end else if (ctrl_reg.half_a_enable && rtc_mode) begin
                  state_reg <= GPT_ST_RTC;
               end
            end
            GPT_ST_COUNT: begin
               if (!ctrl_reg.half_a_enable || ctrl_reg.config_sel != GPT_CFG_32BIT) begin
                  state_reg <= GPT_ST_IDLE;
               end
            end
            GPT_ST_RTC: begin
               if (!ctrl_reg.half_a_enable || !rtc_mode) begin
                  state_reg <= GPT_ST_IDLE;
               end
            end
            default: begin
               state_reg <= GPT_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // counter
   // ==========================================================
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reload_pend_reg <= 1'b0;
      end else begin
         reload_pend_reg <= zero_hit;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rtc_seen_reg <= 1'b0;
      end else begin
         rtc_seen_reg <= rtc_mode;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_a_count_reg <= GPT_HALF_RESET;
         half_b_count_reg <= GPT_HALF_RESET;
      end else if (rtc_mode && !rtc_seen_reg) begin
         {half_b_count_reg, half_a_count_reg} <= GPT_RTC_START;
      end else if (load_write && !rtc_mode) begin
         {half_b_count_reg, half_a_count_reg} <= load_data;
      end else if (state_reg == GPT_ST_COUNT) begin
         if (reload_pend_reg) begin
            {half_b_count_reg, half_a_count_reg} <= load_val;
         end else if (ctrl_reg.half_a_enable && !stalled && count != GPT_ZERO) begin
            // no step once a one-shot has cleared its enable
            {half_b_count_reg, half_a_count_reg} <= count - 32'h0000_0001;
         end
      end else if (state_reg == GPT_ST_RTC && rtc_tick) begin
         if (rtc_hit) begin
            {half_b_count_reg, half_a_count_reg} <= GPT_ZERO;
         end else begin
            {half_b_count_reg, half_a_count_reg} <= count + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // status flags, set wins over clear
   // ==========================================================
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_reg <= '0;
      end else begin
         if (zero_hit) begin
            status_reg.half_a_timeout_raw <= 1'b1;
         end else if (timeout_clear) begin
            status_reg.half_a_timeout_raw <= 1'b0;
         end
         if (zero_hit && ctrl_reg.timeout_mask) begin
            status_reg.half_a_timeout_masked <= 1'b1;
         end else if (timeout_clear || !ctrl_reg.timeout_mask) begin
            status_reg.half_a_timeout_masked <= 1'b0;
         end
         if (rtc_hit) begin
            status_reg.clock_match_raw <= 1'b1;
         end else if (clock_match_clear) begin
            status_reg.clock_match_raw <= 1'b0;
         end
         if (rtc_hit && ctrl_reg.match_mask) begin
            status_reg.clock_match_masked <= 1'b1;
         end else if (clock_match_clear || !ctrl_reg.match_mask) begin
            status_reg.clock_match_masked <= 1'b0;
         end
      end
   end

   // ==========================================================
   // registered outputs
   // ==========================================================
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trigger <= 1'b0;
         controller_irq <= 1'b0;
         half_a_value_reg <= {GPT_HALF_RESET, GPT_HALF_RESET};
      end else begin
         trigger <= zero_hit;
         controller_irq <= (status_reg.half_a_timeout_raw && ctrl_reg.timeout_mask)
                           || (status_reg.clock_match_raw && ctrl_reg.match_mask);
         half_a_value_reg <= count;
      end
   end

   assign ctrl_out = ctrl_reg;
   assign status = status_reg;
endmodule : gpt_timer

/* logic/gpt_pkg.sv */
// package: constants and types for the 32-bit general timer
package gpt_pkg;
   localparam logic [2:0] GPT_CFG_32BIT = 3'h0;
   localparam logic [2:0] GPT_CFG_RTC = 3'h1;
   localparam logic [2:0] GPT_CFG_RESET = 3'h0;
   localparam logic [1:0] GPT_MODE_ONESHOT = 2'h1;
   localparam logic [1:0] GPT_MODE_PERIODIC = 2'h2;
   localparam logic [1:0] GPT_MODE_RESET = 2'h0;
   localparam logic [15:0] GPT_HALF_RESET = 16'hFFFF;
   localparam logic [7:0] GPT_PRESCALE_RESET = 8'h00;
   localparam logic [31:0] GPT_RTC_START = 32'h0000_0001;
   localparam logic [31:0] GPT_ZERO = 32'h0000_0000;
   // rtc input clock and target rate
   localparam int GPT_RTC_IN_HZ = 32768;
   localparam int GPT_RTC_OUT_HZ = 1;
   localparam int GPT_RTC_DIV = GPT_RTC_IN_HZ / GPT_RTC_OUT_HZ;
   localparam logic [14:0] GPT_RTC_DIV_LAST = 15'(GPT_RTC_DIV - 1);

   typedef enum logic [1:0] {
      GPT_ST_IDLE = 2'b00,
      GPT_ST_COUNT = 2'b01,
      GPT_ST_RTC = 2'b10
   } gpt_state_t;

   // software control bits
   typedef struct packed {
      logic [2:0] config_sel;
      logic [1:0] half_a_mode;
      logic [1:0] half_b_mode;
      logic half_a_enable;
      logic half_a_debug_stall;
      logic half_b_debug_stall;
      logic clock_mode_enable;
      logic timeout_mask;
      logic match_mask;
   } gpt_ctrl_t;

   // status flags
   typedef struct packed {
      logic half_a_timeout_raw;
      logic half_a_timeout_masked;
      logic clock_match_raw;
      logic clock_match_masked;
   } gpt_status_t;
endpackage : gpt_pkg

/* logic/gpt_rtc_div.sv */
// module: rtc input edge detector and divide-by-32768 to a 1 Hz enable
module gpt_rtc_div (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic clk_in,
   // output enable pulse
   output logic tick
);
   import gpt_pkg::*;

   logic in_d_reg;
   logic [14:0] div_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_d_reg <= 1'b0;
      end else begin
         in_d_reg <= clk_in;
      end
   end

   // count rising edges of the 32.768 kHz input
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         div_reg <= '0;
         tick <= 1'b0;
      end else if (clk_in && !in_d_reg) begin
         div_reg <= (div_reg == GPT_RTC_DIV_LAST) ? 15'h0000 : div_reg + 15'h0001;
         tick <= (div_reg == GPT_RTC_DIV_LAST);
      end else begin
         tick <= 1'b0;
      end
   end
endmodule : gpt_rtc_div

/* verif/gpt_timer_monitor.sv */
// checker: port properties of the 32-bit general timer
module gpt_timer_monitor
   import gpt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // inputs
   input wire logic load_write,
   input wire logic [31:0] load_data,
   input wire logic prescale_write,
   input wire logic [15:0] prescale_data,
   input wire logic timeout_clear,
   input wire logic clock_match_clear,
   input wire logic debug_halt,
   // outputs
   input wire gpt_pkg::gpt_ctrl_t ctrl_out,
   input wire gpt_pkg::gpt_status_t status,
   input wire logic [31:0] half_a_value_reg,
   input wire logic [15:0] half_a_load_reg,
   input wire logic [15:0] half_b_load_reg,
   input wire logic [7:0] half_a_prescale_reg,
   input wire logic [7:0] half_b_prescale_reg,
   input wire logic controller_irq,
   input wire logic trigger
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_frozen;
      ctrl_out.half_a_enable && debug_halt && ctrl_out.half_a_debug_stall && !ctrl_out.clock_mode_enable
         && ctrl_out.config_sel == GPT_CFG_32BIT;
   endsequence
   sequence s_to_end;
      trigger && ctrl_out.config_sel == GPT_CFG_32BIT;
   endsequence
   AST_LOAD_SPLIT: assert property (load_write |=> {half_b_load_reg, half_a_load_reg} == $past(load_data))
      else $error("load halves wrong");
   AST_PRESCALE: assert property (prescale_write |=> {half_b_prescale_reg, half_a_prescale_reg} == $past(prescale_data))
      else $error("prescale wrong");
   AST_TRIG_PULSE: assert property (trigger |=> !trigger)
      else $error("trigger longer than one cycle");
   AST_TO_HOLD: assert property (status.half_a_timeout_raw && !timeout_clear |=> status.half_a_timeout_raw)
      else $error("timeout flag dropped");
   AST_TO_MASKED: assert property (status.half_a_timeout_masked |-> status.half_a_timeout_raw)
      else $error("masked timeout without raw");
   AST_IRQ: assert property ((status.half_a_timeout_raw && ctrl_out.timeout_mask)
      || (status.clock_match_raw && ctrl_out.match_mask) |=> controller_irq)
      else $error("interrupt missing");
   AST_ONESHOT: assert property (s_to_end ##0 ctrl_out.half_a_mode == GPT_MODE_ONESHOT |-> ##[0:1] !ctrl_out.half_a_enable)
      else $error("one-shot kept running");
   AST_PERIODIC: assert property (s_to_end ##0 ctrl_out.half_a_mode == GPT_MODE_PERIODIC |-> ctrl_out.half_a_enable)
      else $error("periodic stopped");
   AST_STALL: assert property (s_frozen [*4] |-> $stable(half_a_value_reg))
      else $error("count moved in stall");
   AST_MATCH_HOLD: assert property (status.clock_match_raw && !clock_match_clear |=> status.clock_match_raw)
      else $error("match flag dropped");
   AST_MATCH_CLR: assert property (clock_match_clear |=> !status.clock_match_raw && !status.clock_match_masked)
      else $error("match flags not cleared");
   AST_RTC_ROLL: assert property ($rose(status.clock_match_raw) |-> ##[0:2] half_a_value_reg == GPT_ZERO)
      else $error("no roll to zero");
endmodule : gpt_timer_monitor

bind gpt_timer gpt_timer_monitor u_mon (.core_clk(core_clk), .rst(rst), .load_write(load_write),
   .load_data(load_data), .prescale_write(prescale_write), .prescale_data(prescale_data),
   .timeout_clear(timeout_clear), .clock_match_clear(clock_match_clear), .debug_halt(debug_halt),
   .ctrl_out(ctrl_out), .status(status), .half_a_value_reg(half_a_value_reg), .half_a_load_reg(half_a_load_reg),
   .half_b_load_reg(half_b_load_reg), .half_a_prescale_reg(half_a_prescale_reg),
   .half_b_prescale_reg(half_b_prescale_reg), .controller_irq(controller_irq), .trigger(trigger));

/* verif/tb_top.sv */
// testbench: directed scenarios for the 32-bit general timer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import gpt_pkg::*;
   logic core_clk, rst, ctrl_write, load_write, match_write, prescale_write, timeout_clear, clock_match_clear;
   logic debug_halt, capture_pin_0, irq, trig;
   gpt_ctrl_t ctrl_in, ctrl_out;
   gpt_status_t status;
   logic [31:0] load_data, match_data, value, match_val;
   logic [15:0] prescale_data, a_load, b_load;
   logic [7:0] a_pre, b_pre;
   int fails, n_checks, cycles;
   gpt_timer dut (.core_clk(core_clk), .rst(rst), .ctrl_in(ctrl_in), .ctrl_write(ctrl_write),
      .load_write(load_write), .load_data(load_data), .match_write(match_write), .match_data(match_data),
      .prescale_write(prescale_write), .prescale_data(prescale_data), .timeout_clear(timeout_clear),
      .clock_match_clear(clock_match_clear), .debug_halt(debug_halt), .capture_pin_0(capture_pin_0),
      .ctrl_out(ctrl_out), .status(status), .half_a_value_reg(value), .half_a_load_reg(a_load),
      .half_b_load_reg(b_load), .half_a_prescale_reg(a_pre), .half_b_prescale_reg(b_pre),
      .half_a_match_reg(match_val), .controller_irq(irq), .trigger(trig));
   // ====
   // helpers
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task wr_ctrl(input gpt_ctrl_t c);
      @(posedge core_clk);
      ctrl_in <= c;
      ctrl_write <= 1'b1;
      @(posedge core_clk);
      ctrl_write <= 1'b0;
      #1;
   endtask : wr_ctrl
   task wr_load(input logic [31:0] d);
      @(posedge core_clk);
      load_data <= d;
      load_write <= 1'b1;
      @(posedge core_clk);
      load_write <= 1'b0;
      #1;
   endtask : wr_load
   task clr(input logic t, input logic m);
      @(posedge core_clk);
      timeout_clear <= t;
      clock_match_clear <= m;
      @(posedge core_clk);
      timeout_clear <= 1'b0;
      clock_match_clear <= 1'b0;
      #1;
   endtask : clr
   task wait_trig(input int lim);
      int k;
      k = 0;
      while (trig !== 1'b1 && k < lim) begin
         cyc(1);
         k++;
      end
      chk(trig, 1, "trigger");
   endtask : wait_trig
   // ====
   // scenarios
   task t_reset;
      chk(ctrl_out, 0, "ctrl");
      chk(status, 0, "status");
      chk({b_load, a_load}, 32'hFFFF_FFFF, "loads");
      chk(value, 32'hFFFF_FFFF, "count");
      chk({b_pre, a_pre}, 32'h0, "prescale");
      $display("test reset done");
   endtask : t_reset
   task t_load;
      wr_load(32'h0001_0002);
      chk({b_load, a_load}, 32'h0001_0002, "load split");
      @(posedge core_clk);
      prescale_data <= 16'hAB12;
      prescale_write <= 1'b1;
      @(posedge core_clk);
      prescale_write <= 1'b0;
      cyc(3);
      chk(value, 32'h0001_0002, "value join");
      $display("test load done");
   endtask : t_load
   task t_periodic;
      wr_load(32'h6);
      wr_ctrl('{half_a_mode:GPT_MODE_PERIODIC, half_b_mode:GPT_MODE_ONESHOT, half_a_enable:1'b1,
         timeout_mask:1'b1, default:'0});
      wait_trig(14);
      chk(status.half_a_timeout_raw, 1, "raw");
      chk(status.half_a_timeout_masked, 1, "masked");
      chk(ctrl_out.half_a_enable, 1, "still on");
      cyc(1);
      chk(irq, 1, "irq");
      wait_trig(14);
      wr_load(32'h100);
      cyc(3);
      chk(value >= 32'hF0 && value <= 32'h100, 1, "reload");
      wr_ctrl('{default:'0});
      clr(1'b1, 1'b0);
      chk(status.half_a_timeout_raw, 0, "cleared");
      $display("test periodic done");
   endtask : t_periodic
   task t_oneshot;
      wr_load(32'h4);
      wr_ctrl('{half_a_mode:GPT_MODE_ONESHOT, half_b_mode:GPT_MODE_PERIODIC, half_a_enable:1'b1, default:'0});
      wait_trig(12);
      cyc(2);
      chk(ctrl_out.half_a_enable, 0, "enable off");
      chk(status.half_a_timeout_masked, 0, "masked off");
      chk(irq, 0, "no irq when masked");
      cyc(5);
      chk(value, 32'h4, "stopped at load");
      clr(1'b1, 1'b0);
      $display("test oneshot done");
   endtask : t_oneshot
   task t_stall;
      logic [31:0] v;
      wr_load(32'h1000);
      wr_ctrl('{half_a_mode:GPT_MODE_PERIODIC, half_a_enable:1'b1, half_a_debug_stall:1'b1, default:'0});
      @(posedge core_clk);
      debug_halt <= 1'b1;
      cyc(3);
      v = value;
      cyc(8);
      chk(value, v, "frozen");
      @(posedge core_clk);
      debug_halt <= 1'b0;
      cyc(4);
      chk(value < v, 1, "resumed");
      wr_ctrl('{default:'0});
      $display("test stall done");
   endtask : t_stall
   task t_rtc;
      int k;
      @(posedge core_clk);
      match_data <= 32'h1;
      match_write <= 1'b1;
      @(posedge core_clk);
      match_write <= 1'b0;
      wr_ctrl('{config_sel:GPT_CFG_RTC, half_a_enable:1'b1, half_a_debug_stall:1'b1, half_b_debug_stall:1'b1,
         clock_mode_enable:1'b1, match_mask:1'b1, default:'0});
      cyc(2);
      chk(value, GPT_RTC_START, "start one");
      chk(match_val, 32'h0000_0001, "match reg");
      wr_load(32'h50);
      cyc(3);
      chk(value, GPT_RTC_START, "load ignored");
      @(posedge core_clk);
      debug_halt <= 1'b1;
      k = 0;
      while (status.clock_match_raw !== 1'b1 && k < 70000) begin
         @(posedge core_clk);
         capture_pin_0 <= ~capture_pin_0;
         #1;
         k++;
      end
      chk(k >= 65530 && k <= 65545, 1, "one tick");
      cyc(2);
      chk(value, GPT_ZERO, "rolled");
      chk(status.clock_match_masked, 1, "match masked");
      chk(irq, 1, "match irq");
      clr(1'b0, 1'b1);
      chk(status.clock_match_raw, 0, "match cleared");
      @(posedge core_clk);
      debug_halt <= 1'b0;
      $display("test rtc done");
   endtask : t_rtc
   // ====
   // clock, reset, sequence
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         $display("MISMATCH t=%0t run too long", $time);
         give_verdict;
      end
   end
   initial begin
      rst = 1'b1;
      {ctrl_write, load_write, match_write, prescale_write, timeout_clear, clock_match_clear} = '0;
      {debug_halt, capture_pin_0} = '0;
      ctrl_in = '0;
      load_data = '0;
      match_data = '0;
      prescale_data = '0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      cyc(3);
      t_reset;
      t_load;
      t_periodic;
      t_oneshot;
      t_stall;
      t_rtc;
      give_verdict;
   end
endmodule : tb_top
